// ==== rtl/mstx_core.v ====
// Execution unit for nibble swap, skip tests, table reads and exclusive-OR
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "mstx_regs.vh"

// How it works
// - Swap addressed byte nibbles into accumulator
// - Skip next when byte is zero
// - Copy byte to accumulator, skip if zero
// - Skip next when selected bit clear
// - Untaken skip adds no dummy cycle
// - Table read at high:low pointer address
// - Table read in current page
// - Table read in last page
// - Accumulator gets accumulator xor byte
// - Byte gets accumulator xor byte
// - Accumulator gets accumulator xor immediate
module mstx_core (
  // Clock and reset
  input  wire                    core_clk,
  input  wire                    sys_rst,
  // Operation request from the decoder
  input  wire                    op_valid,
  input  wire [`MSTX_OPW-1:0]    op_code,
  input  wire [7:0]              op_addr,
  input  wire [2:0]              op_bit,
  input  wire [`MSTX_DW-1:0]     op_imm,
  output wire                    op_ready,
  // Completion toward the sequencer
  output wire                    exec_done,
  output wire                    skip_next,
  // Page of the executing instruction
  input  wire [`MSTX_PAGE_W-1:0] pc_page,
  // Program memory read port
  output wire [`MSTX_PAW-1:0]    prog_addr,
  output wire                    prog_rd,
  input  wire [`MSTX_PW-1:0]     prog_data,
  // Software register port
  input  wire [`MSTX_RAW-1:0]    reg_addr,
  input  wire [`MSTX_DW-1:0]     reg_wdata,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output wire [`MSTX_DW-1:0]     reg_rdata,
  // Architectural state views
  output wire [`MSTX_DW-1:0]     accumulator,
  output wire                    zero_flag
);

  // ****************************************
  // States
  // ****************************************
  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_DUMMY = 2'b01;
  localparam [1:0] ST_FETCH = 2'b10;
  localparam [1:0] ST_CAPT  = 2'b11;

  // ****************************************
  // Decode helpers
  // ****************************************
  // Operations that may insert the dummy cycle
  function is_skip_op;
    input [`MSTX_OPW-1:0] code;
    begin
      is_skip_op = (code == `MSTX_OP_SKZ) || (code == `MSTX_OP_CPSKZ) ||
                   (code == `MSTX_OP_SZBIT);
    end
  endfunction

  // Operations that read program memory
  function is_table_op;
    input [`MSTX_OPW-1:0] code;
    begin
      is_table_op = (code == `MSTX_OP_TRD_S) || (code == `MSTX_OP_TRD_C) ||
                    (code == `MSTX_OP_TRD_L);
    end
  endfunction

  // ****************************************
  // Storage
  // ****************************************
  reg  [`MSTX_DW-1:0]  data_mem [0:255];
  reg  [1:0]           state_r;
  reg  [1:0]           state_nxt;
  reg  [`MSTX_DW-1:0]  acc_r;
  reg  [`MSTX_DW-1:0]  acc_nxt;
  reg                  zf_r;
  reg                  zf_nxt;
  reg  [`MSTX_DW-1:0]  tptr_lo_r;
  reg  [`MSTX_DW-1:0]  tptr_lo_nxt;
  reg  [`MSTX_DW-1:0]  tptr_hi_r;
  reg  [`MSTX_DW-1:0]  tptr_hi_nxt;
  reg  [`MSTX_DW-1:0]  tlatch_r;
  reg  [`MSTX_DW-1:0]  tlatch_nxt;
  reg  [7:0]           dst_r;
  reg  [7:0]           dst_nxt;
  reg  [`MSTX_PAW-1:0] paddr_r;
  reg  [`MSTX_PAW-1:0] paddr_nxt;
  reg                  prd_r;
  reg                  prd_nxt;
  reg                  done_r;
  reg                  done_nxt;
  reg                  skip_r;
  reg                  skip_nxt;
  reg  [`MSTX_DW-1:0]  rdata_r;
  reg                  mem_we;
  reg  [7:0]           mem_wa;
  reg  [`MSTX_DW-1:0]  mem_wd;

  wire [`MSTX_DW-1:0]  mem_rd;
  wire [`MSTX_DW-1:0]  swap_res;
  wire [`MSTX_DW-1:0]  xor_mem_res;
  wire [`MSTX_DW-1:0]  xor_imm_res;
  wire                 mem_zero;
  wire                 xor_mem_zero;
  wire                 xor_imm_zero;
  wire                 bit_clear;
  wire                 take;
  wire                 sw_ram;
  wire [`MSTX_PAGE_W-1:0] tbl_page;

  // ****************************************
  // Operand fetch and byte operations
  // ****************************************
  // Addressed byte is read combinationally in the issue cycle
  assign mem_rd = data_mem[op_addr];
  assign take   = op_valid && (state_r == ST_IDLE);
  assign sw_ram = reg_addr[`MSTX_RAM_SEL_BIT];
  assign tbl_page = (op_code == `MSTX_OP_TRD_S) ? tptr_hi_r[`MSTX_PAGE_W-1:0] :
                    (op_code == `MSTX_OP_TRD_C) ? pc_page : `MSTX_LAST_PAGE;

  mstx_logic_unit u_logic (
    .acc          (acc_r),
    .mem          (mem_rd),
    .imm          (op_imm),
    .bit_sel      (op_bit),
    .swap_res     (swap_res),
    .xor_mem_res  (xor_mem_res),
    .xor_imm_res  (xor_imm_res),
    .mem_zero     (mem_zero),
    .xor_mem_zero (xor_mem_zero),
    .xor_imm_zero (xor_imm_zero),
    .bit_clear    (bit_clear)
  );

  // ****************************************
  // Next-state and datapath decisions
  // ****************************************
  // Software writes come first so an executing operation overrides them
  always @* begin
    state_nxt = state_r;
    acc_nxt   = acc_r;
    zf_nxt    = zf_r;
    tptr_lo_nxt = tptr_lo_r;
    tptr_hi_nxt = tptr_hi_r;
    tlatch_nxt  = tlatch_r;
    dst_nxt   = dst_r;
    paddr_nxt = paddr_r;
    prd_nxt   = 1'b0;
    done_nxt  = 1'b0;
    skip_nxt  = 1'b0;
    mem_we    = 1'b0;
    mem_wa    = reg_addr[7:0];
    mem_wd    = reg_wdata;

    // Software access to the architectural registers
    if (reg_wr) begin
      if (sw_ram) begin
        mem_we = 1'b1;
      end else begin
        case (reg_addr)
          `MSTX_OFS_ACC:    acc_nxt  = reg_wdata;
          `MSTX_OFS_TPTR_LO: tptr_lo_nxt = reg_wdata;
          `MSTX_OFS_TPTR_HI: tptr_hi_nxt = reg_wdata;
          `MSTX_OFS_TLATCH:  tlatch_nxt  = reg_wdata;
          `MSTX_OFS_STATUS: zf_nxt   = reg_wdata[`MSTX_ST_ZERO_BIT];
          default:          acc_nxt  = acc_r;
        endcase
      end
    end

    case (state_r)
      ST_IDLE: begin
        if (take) begin
          case (op_code)
            `MSTX_OP_NSWAP: begin
              acc_nxt  = swap_res;
              done_nxt = 1'b1;
            end
            `MSTX_OP_SKZ: begin
              if (mem_zero) begin
                state_nxt = ST_DUMMY;
                skip_nxt  = 1'b1;
              end else begin
                done_nxt  = 1'b1;
              end
            end
            `MSTX_OP_CPSKZ: begin
              acc_nxt = mem_rd;
              if (mem_zero) begin
                state_nxt = ST_DUMMY;
                skip_nxt  = 1'b1;
              end else begin
                done_nxt  = 1'b1;
              end
            end
            `MSTX_OP_SZBIT: begin
              if (bit_clear) begin
                state_nxt = ST_DUMMY;
                skip_nxt  = 1'b1;
              end else begin
                done_nxt  = 1'b1;
              end
            end
            `MSTX_OP_TRD_S, `MSTX_OP_TRD_C, `MSTX_OP_TRD_L: begin
              paddr_nxt = {tbl_page, tptr_lo_r};
              prd_nxt   = 1'b1;
              dst_nxt   = op_addr;
              state_nxt = ST_FETCH;
            end
            `MSTX_OP_XOR_A: begin
              acc_nxt  = xor_mem_res;
              zf_nxt   = xor_mem_zero;
              done_nxt = 1'b1;
            end
            `MSTX_OP_XOR_M: begin
              mem_we   = 1'b1;
              mem_wa   = op_addr;
              mem_wd   = xor_mem_res;
              acc_nxt  = acc_r;
              zf_nxt   = xor_mem_zero;
              done_nxt = 1'b1;
            end
            `MSTX_OP_XOR_I: begin
              acc_nxt  = xor_imm_res;
              zf_nxt   = xor_imm_zero;
              done_nxt = 1'b1;
            end
            // Unknown codes retire with no effect so the sequencer never hangs
            default: begin
              done_nxt = 1'b1;
            end
          endcase
        end
      end

      // dummy cycle while next is fetched
      ST_DUMMY: begin
        state_nxt = ST_IDLE;
        done_nxt  = 1'b1;
      end

      // Program word is presented one cycle after the read strobe
      ST_FETCH: begin
        state_nxt = ST_CAPT;
      end

      // low byte to data, high to latch
      ST_CAPT: begin
        mem_we    = 1'b1;
        mem_wa    = dst_r;
        mem_wd    = prog_data[7:0];
        tlatch_nxt = prog_data[15:8];
        done_nxt  = 1'b1;
        state_nxt = ST_IDLE;
      end

      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // Architectural and control registers
  // ****************************************
  // Synchronous reset of every control flop
  always @(posedge core_clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      acc_r   <= `MSTX_RST_BYTE;
      zf_r    <= 1'b0;
      tptr_lo_r <= `MSTX_RST_BYTE;
      tptr_hi_r <= `MSTX_RST_BYTE;
      tlatch_r  <= `MSTX_RST_BYTE;
      dst_r   <= 8'h00;
      paddr_r <= `MSTX_RST_PADDR;
      prd_r   <= 1'b0;
      done_r  <= 1'b0;
      skip_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      acc_r   <= acc_nxt;
      zf_r    <= zf_nxt;
      tptr_lo_r <= tptr_lo_nxt;
      tptr_hi_r <= tptr_hi_nxt;
      tlatch_r  <= tlatch_nxt;
      dst_r   <= dst_nxt;
      paddr_r <= paddr_nxt;
      prd_r   <= prd_nxt;
      done_r  <= done_nxt;
      skip_r  <= skip_nxt;
    end
  end

  // ****************************************
  // Data memory
  // ****************************************
  // Contents are not reset; software must initialise what it reads
  always @(posedge core_clk) begin
    if (mem_we) begin
      data_mem[mem_wa] <= mem_wd;
    end
  end

  // ****************************************
  // Software read port
  // ****************************************
  // Data stand in the cycle after the strobe; unmapped reads give zero
  always @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      if (sw_ram) begin
        rdata_r <= data_mem[reg_addr[7:0]];
      end else begin
        case (reg_addr)
          `MSTX_OFS_ACC:    rdata_r <= acc_r;
          `MSTX_OFS_TPTR_LO: rdata_r <= tptr_lo_r;
          `MSTX_OFS_TPTR_HI: rdata_r <= tptr_hi_r;
          `MSTX_OFS_TLATCH:  rdata_r <= tlatch_r;
          `MSTX_OFS_STATUS: rdata_r <= {6'h00, (state_r != ST_IDLE), zf_r};
          default:          rdata_r <= 8'h00;
        endcase
      end
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Ready is combinational so a new op may follow in the done cycle
  assign op_ready    = (state_r == ST_IDLE);
  assign exec_done   = done_r;
  assign skip_next   = skip_r;
  assign prog_addr   = paddr_r;
  assign prog_rd     = prd_r;
  assign reg_rdata   = rdata_r;
  assign accumulator = acc_r;
  assign zero_flag   = zf_r;

endmodule // mstx_core

// ==== inc/mstx_regs.vh ====
// Constants for the skip, table-read and exclusive-OR execution unit
`ifndef MSTX_REGS_VH
`define MSTX_REGS_VH

// ****************************************
// Widths
// ****************************************
`define MSTX_DW          8
`define MSTX_PW          16
`define MSTX_PAW         12
`define MSTX_PAGE_W      4
`define MSTX_RAW         9
`define MSTX_OPW         4

// ****************************************
// Register offsets (software port)
// ****************************************
`define MSTX_OFS_ACC     9'h000
`define MSTX_OFS_TPTR_LO 9'h001
`define MSTX_OFS_TPTR_HI 9'h002
`define MSTX_OFS_TLATCH  9'h003
`define MSTX_OFS_STATUS  9'h004
`define MSTX_RAM_SEL_BIT 8

// ****************************************
// Status fields and reset values
// ****************************************
`define MSTX_ST_ZERO_BIT 0
`define MSTX_ST_BUSY_BIT 1
`define MSTX_RST_BYTE    8'h00
`define MSTX_RST_PADDR   12'h000
`define MSTX_LAST_PAGE   4'hf

// ****************************************
// Operation codes
// ****************************************
`define MSTX_OP_NSWAP    4'h0
`define MSTX_OP_SKZ      4'h1
`define MSTX_OP_CPSKZ    4'h2
`define MSTX_OP_SZBIT    4'h3
`define MSTX_OP_TRD_S    4'h4
`define MSTX_OP_TRD_C    4'h5
`define MSTX_OP_TRD_L    4'h6
`define MSTX_OP_XOR_A    4'h7
`define MSTX_OP_XOR_M    4'h8
`define MSTX_OP_XOR_I    4'h9

// ****************************************
// Timing counts in core cycles
// ****************************************
`define MSTX_SKIP_CYCLES 2
`define MSTX_PROG_LAT    1

`endif

// ==== rtl/mstx_logic_unit.v ====
// Combinational byte operations: nibble swap, exclusive-OR, zero and bit tests
`timescale 1ns/10ps
`include "mstx_regs.vh"

module mstx_logic_unit (
  // Operands
  input  wire [`MSTX_DW-1:0] acc,
  input  wire [`MSTX_DW-1:0] mem,
  input  wire [`MSTX_DW-1:0] imm,
  input  wire [2:0]          bit_sel,
  // Results
  output wire [`MSTX_DW-1:0] swap_res,
  output wire [`MSTX_DW-1:0] xor_mem_res,
  output wire [`MSTX_DW-1:0] xor_imm_res,
  output wire                mem_zero,
  output wire                xor_mem_zero,
  output wire                xor_imm_zero,
  output wire                bit_clear
);

  genvar i;

  // ****************************************
  // Nibble swap
  // ****************************************
  // high nibble to low
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_swap
      assign swap_res[i]     = mem[i+4];
      assign swap_res[i+4]   = mem[i];
    end
  endgenerate

  assign xor_mem_res  = acc ^ mem;
  assign xor_imm_res  = acc ^ imm;

  assign xor_mem_zero = (xor_mem_res == 8'h00);
  assign xor_imm_zero = (xor_imm_res == 8'h00);

  assign mem_zero     = (mem == 8'h00);
  assign bit_clear    = ~mem[bit_sel];

endmodule // mstx_logic_unit

// ==== tb/mstx_core_asserts.sv ====
// Port checker for the skip, table-read and exclusive-OR unit
`timescale 1ns/10ps
// ****************
// Checker
// ****************
module mstx_core_chk (
  // Clock and reset
  input wire        core_clk,
  input wire        sys_rst,
  // Operation port
  input wire        op_valid,
  input wire [3:0]  op_code,
  input wire [7:0]  op_imm,
  input wire        op_ready,
  input wire        exec_done,
  input wire        skip_next,
  // Program side and state
  input wire [3:0]  pc_page,
  input wire [11:0] prog_addr,
  input wire        prog_rd,
  input wire [7:0]  accumulator,
  input wire        zero_flag
);
  // Request taken at this edge
  wire tk;
  assign tk = op_valid && op_ready;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  chk_swap_no_flag: assert property (
    tk && op_code == 4'h0 |=> exec_done && !skip_next && $stable(zero_flag))
    else $error("swap changed flag");
  chk_skip_keeps_state: assert property (
    tk && (op_code == 4'h1 || op_code == 4'h3) |=> $stable(accumulator) && $stable(zero_flag))
    else $error("skip test changed state");
  chk_copy_skip_zero: assert property (
    tk && op_code == 4'h2 |=> skip_next == (accumulator == 8'h00) && $stable(zero_flag))
    else $error("copy skip mismatch");
  chk_dummy_cycle: assert property (
    skip_next |-> !op_ready ##1 (exec_done && op_ready && !skip_next))
    else $error("dummy cycle wrong");
  chk_no_dummy: assert property (
    (tk && op_code >= 4'h1 && op_code <= 4'h3) ##1 !skip_next |-> exec_done)
    else $error("untaken skip stalled");
  chk_table_timing: assert property (
    tk && op_code == 4'h4 |=> !op_ready && prog_rd ##1 !op_ready && !prog_rd ##1 exec_done && op_ready)
    else $error("table read timing");
  chk_table_cur_page: assert property (
    tk && op_code == 4'h5 |=> prog_rd && prog_addr[11:8] == $past(pc_page))
    else $error("current page wrong");
  chk_table_last_page: assert property (
    tk && op_code == 4'h6 |=> prog_rd && prog_addr[11:8] == 4'hf)
    else $error("last page wrong");
  chk_xor_acc_zero: assert property (
    tk && op_code == 4'h7 |=> exec_done && zero_flag == (accumulator == 8'h00))
    else $error("xor zero flag");
  chk_xor_imm: assert property (
    tk && op_code == 4'h9 |=> accumulator == ($past(accumulator) ^ $past(op_imm)) &&
    zero_flag == (accumulator == 8'h00))
    else $error("xor immediate wrong");
  chk_xor_mem_acc: assert property (
    tk && op_code == 4'h8 |=> exec_done && $stable(accumulator))
    else $error("xor to memory hit accumulator");
endmodule // mstx_core_chk

bind mstx_core mstx_core_chk chk_u (.core_clk(core_clk), .sys_rst(sys_rst), .op_valid(op_valid),
  .op_code(op_code), .op_imm(op_imm), .op_ready(op_ready), .exec_done(exec_done), .skip_next(skip_next),
  .pc_page(pc_page), .prog_addr(prog_addr), .prog_rd(prog_rd), .accumulator(accumulator), .zero_flag(zero_flag));

// ==== tb/testbench.sv ====
// Self-checking bench for the skip, table-read and exclusive-OR unit
`timescale 1ns/10ps
module testbench;
  // ****************
  // Stimulus and observation
  // ****************
  reg         core_clk, sys_rst, op_valid, reg_wr, reg_rd;
  reg  [3:0]  op_code, pc_page;
  reg  [7:0]  op_addr, op_imm, reg_wdata;
  reg  [2:0]  op_bit;
  reg  [15:0] prog_data;
  reg  [8:0]  reg_addr;
  wire        op_ready, exec_done, skip_next, prog_rd, zero_flag;
  wire [11:0] prog_addr;
  wire [7:0]  reg_rdata, accumulator;
  integer     bad_count, checks_done;

  mstx_core dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .op_valid(op_valid), .op_code(op_code),
    .op_addr(op_addr), .op_bit(op_bit), .op_imm(op_imm), .op_ready(op_ready), .exec_done(exec_done),
    .skip_next(skip_next), .pc_page(pc_page), .prog_addr(prog_addr), .prog_rd(prog_rd),
    .prog_data(prog_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .accumulator(accumulator), .zero_flag(zero_flag));

  // Core clock, 10 ns
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Program store: valid only after the strobe, scrambled otherwise so stale data is caught
  always @(posedge core_clk) begin
    if (prog_rd) begin
      prog_data <= {prog_addr[11:8], 4'h6, prog_addr[7:0] ^ {prog_addr[11:8], 4'h0}};
    end else begin
      prog_data <= ~prog_data;
    end
  end

  // ****************
  // Shared tasks
  // ****************
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  task end_of_test;
    begin
      $display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
        $display("No errors found");
      end else begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask

  task wr(input [8:0] a, input [7:0] d);
    begin
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
    end
  endtask

  // Read data stands only in the cycle after the strobe
  task rdc(input [8:0] a, input [7:0] e);
    begin
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1;
      chk(reg_rdata, e);
    end
  endtask

  // One operation; counts cycles to completion and notes any skip
  task op(input [3:0] c, input [7:0] a, input [2:0] b, input [7:0] i, input [1:0] cyc, input sk);
    integer n;
    reg     s;
    begin
      @(posedge core_clk);
      op_valid <= 1'b1;
      op_code  <= c;
      op_addr  <= a;
      op_bit   <= b;
      op_imm   <= i;
      @(posedge core_clk);
      op_valid <= 1'b0;
      n = 1;
      s = 1'b0;
      #1;
      while (exec_done !== 1'b1 && n < 8) begin
        s = s | skip_next;
        @(posedge core_clk);
        #1;
        n = n + 1;
      end
      if (n >= 8) begin
        bad_count = bad_count + 1;
        end_of_test;
      end
      chk(n, cyc);
      chk(s, sk);
    end
  endtask

  // ****************
  // Scenarios
  // ****************
  task t_regs;
    integer k;
    begin
      for (k = 0; k < 6; k = k + 1) begin
        rdc(k, 8'h00);
      end
      wr(9'h005, 8'h77);
      rdc(9'h005, 8'h00);
      wr(9'h004, 8'h03);
      rdc(9'h004, 8'h01);
      chk(zero_flag, 1'b1);
    end
  endtask

  task t_swap;
    begin
      wr(9'h110, 8'ha5);
      op(4'h0, 8'h10, 3'h0, 8'h00, 2'd1, 1'b0);
      chk(accumulator, 8'h5a);
      chk(zero_flag, 1'b1);
      rdc(9'h110, 8'ha5);
    end
  endtask

  // Flag cleared first so a copy of zero cannot pass by setting it
  task t_skip;
    begin
      wr(9'h004, 8'h00);
      wr(9'h111, 8'h00);
      wr(9'h112, 8'h80);
      wr(9'h113, 8'h7f);
      op(4'h1, 8'h11, 3'h0, 8'h00, 2'd2, 1'b1);
      op(4'h1, 8'h12, 3'h0, 8'h00, 2'd1, 1'b0);
      chk(accumulator, 8'h5a);
      op(4'h3, 8'h12, 3'h7, 8'h00, 2'd1, 1'b0);
      op(4'h3, 8'h13, 3'h7, 8'h00, 2'd2, 1'b1);
      op(4'h3, 8'h13, 3'h0, 8'h00, 2'd1, 1'b0);
      op(4'h3, 8'h12, 3'h0, 8'h00, 2'd2, 1'b1);
      op(4'h2, 8'h12, 3'h0, 8'h00, 2'd1, 1'b0);
      chk(accumulator, 8'h80);
      op(4'h2, 8'h11, 3'h0, 8'h00, 2'd2, 1'b1);
      chk(accumulator, 8'h00);
      chk(zero_flag, 1'b0);
    end
  endtask

  task t_table;
    begin
      wr(9'h001, 8'h34);
      wr(9'h002, 8'h07);
      @(posedge core_clk);
      pc_page <= 4'h9;
      op(4'h4, 8'h20, 3'h0, 8'h00, 2'd3, 1'b0);
      rdc(9'h120, 8'h44);
      rdc(9'h003, 8'h76);
      op(4'h5, 8'h21, 3'h0, 8'h00, 2'd3, 1'b0);
      rdc(9'h121, 8'ha4);
      rdc(9'h003, 8'h96);
      op(4'h6, 8'h22, 3'h0, 8'h00, 2'd3, 1'b0);
      rdc(9'h122, 8'hc4);
      rdc(9'h003, 8'hf6);
    end
  endtask

  task t_xor;
    begin
      wr(9'h000, 8'h3c);
      wr(9'h130, 8'h3c);
      wr(9'h131, 8'hff);
      op(4'h7, 8'h30, 3'h0, 8'h00, 2'd1, 1'b0);
      chk(accumulator, 8'h00);
      chk(zero_flag, 1'b1);
      op(4'h9, 8'h00, 3'h0, 8'hff, 2'd1, 1'b0);
      chk(accumulator, 8'hff);
      chk(zero_flag, 1'b0);
      op(4'h8, 8'h30, 3'h0, 8'h00, 2'd1, 1'b0);
      rdc(9'h130, 8'hc3);
      chk(accumulator, 8'hff);
      chk(zero_flag, 1'b0);
      op(4'h8, 8'h31, 3'h0, 8'h00, 2'd1, 1'b0);
      rdc(9'h131, 8'h00);
      chk(accumulator, 8'hff);
      chk(zero_flag, 1'b1);
      op(4'ha, 8'h31, 3'h0, 8'h00, 2'd1, 1'b0);
      chk(accumulator, 8'hff);
    end
  endtask

  // ****************
  // Main sequence
  // ****************
  initial begin
    bad_count   = 0;
    checks_done = 0;
    sys_rst     = 1'b1;
    op_valid    = 1'b0;
    op_code     = 4'h0;
    op_addr     = 8'h00;
    op_bit      = 3'h0;
    op_imm      = 8'h00;
    pc_page     = 4'h2;
    prog_data   = 16'h0000;
    reg_addr    = 9'h000;
    reg_wdata   = 8'h00;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    t_regs;
    t_swap;
    t_skip;
    t_table;
    t_xor;
    end_of_test;
  end
endmodule // testbench
